// ### rtl/smpf_pkg.sv
// Constants for the system-management pin function block
package smpf_pkg;
   localparam int          CLK_HZ          = 40_000_000;
   localparam int          SLOW_CLK_HZ     = 32_768;
   // Slow clock toggles twice per period; fractional accumulator step and modulus
   localparam logic [26:0] SLOW_STEP       = 27'(2 * SLOW_CLK_HZ);
   localparam logic [26:0] SLOW_MOD        = 27'(CLK_HZ);

   localparam logic [7:0]  OFS_STATUS      = 8'h00;
   localparam logic [7:0]  OFS_CTRL        = 8'h04;
   localparam logic [7:0]  OFS_FAN_CFG     = 8'h08;
   localparam logic [7:0]  OFS_TACH        = 8'h0C;
   localparam logic [7:0]  OFS_FUNC_SEL    = 8'h10;
   localparam logic [7:0]  OFS_GPIO_OE     = 8'h14;
   localparam logic [7:0]  OFS_GPIO_OUT    = 8'h18;
   localparam logic [7:0]  OFS_GPIO_IN     = 8'h1C;

   // Status bits
   localparam int          ST_AC_FLAG      = 0;
   localparam int          ST_IRQ_FLAG     = 1;
   localparam int          ST_AC_LEVEL     = 2;
   localparam int          ST_BAT_LEVEL    = 3;
   localparam int          ST_RESUME_BLK   = 4;
   localparam int          ST_KEEP_LEVEL   = 5;
   // Control bits
   localparam int          CT_GFX_C3EN     = 0;
   localparam int          CT_DOZE_C3EN    = 1;
   localparam int          CT_GFX_DIRECT   = 2;
   localparam int          CT_DOZE_DIRECT  = 3;
   localparam int          CT_CLKH_DIRECT  = 4;
   localparam int          CT_MEMH_DIRECT  = 5;
   localparam int          CT_KEEP_REQ     = 6;
   localparam logic [6:0]  CTRL_RESET      = 7'h00;
   // Fan config: [7:0] prescale, [15:8] duty
   localparam logic [15:0] FAN_CFG_RESET   = 16'h8000;
   localparam logic [15:0] TACH_RESET      = 16'h0000;

   // Pin indices of multiplexed functions
   localparam int          PIN_AC          = 0;
   localparam int          PIN_GFX         = 1;
   localparam int          PIN_BAT         = 2;
   localparam int          PIN_SLOW        = 3;
   localparam int          PIN_KEEP        = 5;
   localparam int          PIN_DOZE        = 6;
   localparam int          PIN_CLKH        = 7;
   localparam int          PIN_FAN1        = 9;
   localparam int          PIN_TACH        = 10;
   // Pins that own a special function; all others are general purpose only
   localparam logic [31:0] FUNC_MASK       = 32'h000006EF;
   localparam logic [31:0] FUNC_SEL_RESET  = 32'h00000000;
   localparam logic [31:0] GPIO_OE_RESET   = 32'h00000000;
   localparam logic [31:0] GPIO_OUT_RESET  = 32'h00000000;
   // Pin drivers in reset: graphics halt and clock halt driven high, fan 1 driven low
   localparam logic [31:0] PAD_OUT_RESET   = 32'h00000082;
   localparam logic [31:0] PAD_OE_RESET    = 32'h00000282;

   localparam logic [1:0]  RESP_OKAY       = 2'h0;
   localparam logic [1:0]  RESP_SLVERR     = 2'h2;
endpackage

// ### rtl/smpf_top.sv
// System-management pin functions with AXI4-Lite register access
//
// Local design decisions: the AXI4-Lite register port and the register offsets.
module smpf_top (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        c3_active,
   input  wire logic        sleep_s1,
   input  wire logic        sleep_s3_s5,
   input  wire logic        mechanical_off_state,
   input  wire logic        external_mgmt_irq_n,
   input  wire logic [31:0] pad_in,
   output logic [31:0]      pad_out,
   output logic [31:0]      pad_oe,
   output logic             fan_drive_out0,
   output logic             memctl_halt_n,
   output logic             resume_block,
   output logic             resume_event
);
   logic [31:0] pad_meta_r;
   logic [31:0] pad_sync_r;
   logic        irq_meta_r;
   logic        irq_sync_r;
   logic        irq_prev_r;
   logic        ac_prev_r;
   logic        tach_prev_r;
   logic [1:0]  status_flags_r;
   logic [6:0]  ctrl_r;
   logic [15:0] fan_cfg_r;
   logic [15:0] tach_r;
   logic [31:0] func_sel_r;
   logic [31:0] gpio_oe_r;
   logic [31:0] gpio_out_r;
   logic [7:0]  fan_pre_r;
   logic [7:0]  fan_cnt_r;
   logic        fan_r;
   logic [26:0] slow_acc_r;
   logic        slow_clk_r;
   logic        aw_got_r;
   logic        w_got_r;
   logic [7:0]  awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0]  wstrb_r;
   logic [31:0] pad_out_r;
   logic [31:0] pad_oe_r;
   logic        memh_r;
   logic        resume_ev_r;
   logic        wr_go;
   logic [31:0] gpio_sel;
   logic        ac_present;
   logic        bat_weak;
   logic        keep_avail;
   logic        gfx_halt;
   logic        doze;
   logic        ac_edge;
   logic        irq_edge;
   logic        tach_edge;
   logic [31:0] func_out;
   logic [31:0] func_oe;
   logic [31:0] rd_val;
   logic        rd_hit;
   logic [1:0]  bresp_r;
   logic        bvalid_r;
   logic [31:0] rdata_r;
   logic [1:0]  rresp_r;
   logic        rvalid_r;

   function automatic logic [31:0] merge_strb(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] strb);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return res;
   endfunction

   function automatic logic known_ofs(input logic [7:0] a);
      return a == smpf_pkg::OFS_STATUS || a == smpf_pkg::OFS_CTRL || a == smpf_pkg::OFS_FAN_CFG
          || a == smpf_pkg::OFS_TACH || a == smpf_pkg::OFS_FUNC_SEL || a == smpf_pkg::OFS_GPIO_OE
          || a == smpf_pkg::OFS_GPIO_OUT || a == smpf_pkg::OFS_GPIO_IN;
   endfunction

   // Pin synchronisers
   always_ff @(posedge aclk) begin
      pad_meta_r <= pad_in;
      pad_sync_r <= pad_meta_r;
      irq_meta_r <= external_mgmt_irq_n;
      irq_sync_r <= irq_meta_r;
   end

   // Function inputs; an unselected function reads as its idle level
   assign gpio_sel   = func_sel_r | ~smpf_pkg::FUNC_MASK;
   assign ac_present = gpio_sel[smpf_pkg::PIN_AC] | pad_sync_r[smpf_pkg::PIN_AC];
   assign bat_weak   = ~gpio_sel[smpf_pkg::PIN_BAT] & ~pad_sync_r[smpf_pkg::PIN_BAT];
   assign resume_block = bat_weak & ~ac_present;
   assign ac_edge    = ac_present ^ ac_prev_r;
   assign irq_edge   = irq_prev_r & ~irq_sync_r;
   assign tach_edge  = ~gpio_sel[smpf_pkg::PIN_TACH] & pad_sync_r[smpf_pkg::PIN_TACH] & ~tach_prev_r;
   assign keep_avail = ~sleep_s3_s5 & ~mechanical_off_state;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ac_prev_r   <= 1'b1;
         irq_prev_r  <= 1'b1;
         tach_prev_r <= 1'b0;
         resume_ev_r <= 1'b0;
      end else begin
         ac_prev_r   <= ac_present;
         irq_prev_r  <= irq_sync_r;
         tach_prev_r <= pad_sync_r[smpf_pkg::PIN_TACH];
         resume_ev_r <= irq_edge;
      end
   end

   // AXI write channel capture
   assign wr_go = aw_got_r & w_got_r & ~bvalid_r;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_r <= 1'b0;
         w_got_r  <= 1'b0;
         awaddr_r <= 8'h00;
         wdata_r  <= 32'h00000000;
         wstrb_r  <= 4'h0;
         bvalid_r <= 1'b0;
         bresp_r  <= smpf_pkg::RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_got_r <= 1'b0;
            w_got_r  <= 1'b0;
            bvalid_r <= 1'b1;
            bresp_r  <= known_ofs(awaddr_r) ? smpf_pkg::RESP_OKAY : smpf_pkg::RESP_SLVERR;
         end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   assign s_axi_awready = ~aw_got_r & ~bvalid_r;
   assign s_axi_wready  = ~w_got_r & ~bvalid_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;

   // Sticky event flags, write one to clear, a new event wins over the clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status_flags_r <= 2'h0;
      end else begin
         if (wr_go && awaddr_r == smpf_pkg::OFS_STATUS && wstrb_r[0]) begin
            status_flags_r <= status_flags_r & ~wdata_r[1:0];
         end
         if (ac_edge) begin
            status_flags_r[smpf_pkg::ST_AC_FLAG] <= 1'b1;
         end
         if (irq_edge) begin
            status_flags_r[smpf_pkg::ST_IRQ_FLAG] <= 1'b1;
         end
      end
   end

   // Control and configuration registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_r     <= smpf_pkg::CTRL_RESET;
         fan_cfg_r  <= smpf_pkg::FAN_CFG_RESET;
         func_sel_r <= smpf_pkg::FUNC_SEL_RESET;
         gpio_oe_r  <= smpf_pkg::GPIO_OE_RESET;
         gpio_out_r <= smpf_pkg::GPIO_OUT_RESET;
      end else if (wr_go) begin
         case (awaddr_r)
            smpf_pkg::OFS_CTRL: begin
               ctrl_r <= 7'(merge_strb({25'h0, ctrl_r}, wdata_r, wstrb_r));
            end
            smpf_pkg::OFS_FAN_CFG: begin
               fan_cfg_r <= 16'(merge_strb({16'h0, fan_cfg_r}, wdata_r, wstrb_r));
            end
            smpf_pkg::OFS_FUNC_SEL: begin
               func_sel_r <= merge_strb(func_sel_r, wdata_r, wstrb_r) & smpf_pkg::FUNC_MASK;
            end
            smpf_pkg::OFS_GPIO_OE: begin
               gpio_oe_r <= merge_strb(gpio_oe_r, wdata_r, wstrb_r);
            end
            smpf_pkg::OFS_GPIO_OUT: begin
               gpio_out_r <= merge_strb(gpio_out_r, wdata_r, wstrb_r);
            end
            default: begin
            end
         endcase
      end
   end

   // Tachometer edge counter; a write clears it, an edge in that cycle counts one
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tach_r <= smpf_pkg::TACH_RESET;
      end else if (wr_go && awaddr_r == smpf_pkg::OFS_TACH) begin
         tach_r <= {15'h0, tach_edge};
      end else if (tach_edge) begin
         tach_r <= tach_r + 16'h0001;
      end
   end

   // Fan PWM: prescaler paces an 8-bit phase, output high while phase below duty
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fan_pre_r <= 8'h00;
         fan_cnt_r <= 8'h00;
         fan_r     <= 1'b0;
      end else begin
         if (fan_pre_r >= fan_cfg_r[7:0]) begin
            fan_pre_r <= 8'h00;
            fan_cnt_r <= fan_cnt_r + 8'h01;
         end else begin
            fan_pre_r <= fan_pre_r + 8'h01;
         end
         fan_r <= fan_cnt_r < fan_cfg_r[15:8];
      end
   end

   // 32.768 kHz slow clock from fractional accumulator
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         slow_acc_r <= 27'h0000000;
         slow_clk_r <= 1'b0;
      end else if (mechanical_off_state) begin
         slow_acc_r <= 27'h0000000;
         slow_clk_r <= 1'b0;
      end else if (slow_acc_r + smpf_pkg::SLOW_STEP >= smpf_pkg::SLOW_MOD) begin
         slow_acc_r <= slow_acc_r + smpf_pkg::SLOW_STEP - smpf_pkg::SLOW_MOD;
         slow_clk_r <= ~slow_clk_r;
      end else begin
         slow_acc_r <= slow_acc_r + smpf_pkg::SLOW_STEP;
      end
   end

   // Special function outputs; one means asserted, pins go low
   assign gfx_halt = ctrl_r[smpf_pkg::CT_GFX_DIRECT] | sleep_s3_s5
                   | (ctrl_r[smpf_pkg::CT_GFX_C3EN] & (c3_active | sleep_s1));
   assign doze     = ctrl_r[smpf_pkg::CT_DOZE_DIRECT]
                   | (ctrl_r[smpf_pkg::CT_DOZE_C3EN] & c3_active);

   always_comb begin
      func_out = 32'h00000000;
      func_oe  = 32'h00000000;
      func_out[smpf_pkg::PIN_GFX]  = ~gfx_halt;
      func_oe[smpf_pkg::PIN_GFX]   = 1'b1;
      func_out[smpf_pkg::PIN_SLOW] = slow_clk_r & ~mechanical_off_state;
      func_oe[smpf_pkg::PIN_SLOW]  = 1'b1;
      func_oe[smpf_pkg::PIN_KEEP]  = keep_avail & ctrl_r[smpf_pkg::CT_KEEP_REQ];
      func_oe[smpf_pkg::PIN_DOZE]  = doze;
      func_out[smpf_pkg::PIN_CLKH] = ~ctrl_r[smpf_pkg::CT_CLKH_DIRECT];
      func_oe[smpf_pkg::PIN_CLKH]  = 1'b1;
      func_out[smpf_pkg::PIN_FAN1] = fan_r;
      func_oe[smpf_pkg::PIN_FAN1]  = 1'b1;
   end

   // Pin drivers registered; halt outputs reset high, fan 1 driven low, others released
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pad_out_r <= smpf_pkg::PAD_OUT_RESET;
         pad_oe_r  <= smpf_pkg::PAD_OE_RESET;
         memh_r    <= 1'b0;
      end else begin
         for (int n = 0; n < 32; n++) begin
            pad_out_r[n] <= gpio_sel[n] ? gpio_out_r[n] : func_out[n];
            pad_oe_r[n]  <= gpio_sel[n] ? gpio_oe_r[n] : func_oe[n];
         end
         memh_r <= ctrl_r[smpf_pkg::CT_MEMH_DIRECT];
      end
   end

   assign pad_out        = pad_out_r;
   assign pad_oe         = pad_oe_r;
   assign fan_drive_out0 = fan_r;
   assign memctl_halt_n  = ~memh_r;
   assign resume_event   = resume_ev_r;

   // Register read mux
   always_comb begin
      rd_val = 32'h00000000;
      rd_hit = 1'b1;
      case (s_axi_araddr)
         smpf_pkg::OFS_STATUS: begin
            rd_val[1:0] = status_flags_r;
            rd_val[smpf_pkg::ST_AC_LEVEL]   = ac_present;
            rd_val[smpf_pkg::ST_BAT_LEVEL]  = ~bat_weak;
            rd_val[smpf_pkg::ST_RESUME_BLK] = resume_block;
            rd_val[smpf_pkg::ST_KEEP_LEVEL] = pad_sync_r[smpf_pkg::PIN_KEEP];
         end
         smpf_pkg::OFS_CTRL:     rd_val[6:0]  = ctrl_r;
         smpf_pkg::OFS_FAN_CFG:  rd_val[15:0] = fan_cfg_r;
         smpf_pkg::OFS_TACH:     rd_val[15:0] = tach_r;
         smpf_pkg::OFS_FUNC_SEL: rd_val = func_sel_r;
         smpf_pkg::OFS_GPIO_OE:  rd_val = gpio_oe_r;
         smpf_pkg::OFS_GPIO_OUT: rd_val = gpio_out_r;
         smpf_pkg::OFS_GPIO_IN:  rd_val = pad_sync_r;
         default: rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_r <= 1'b0;
         rdata_r  <= 32'h00000000;
         rresp_r  <= smpf_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && !rvalid_r) begin
         rvalid_r <= 1'b1;
         rdata_r  <= rd_val;
         rresp_r  <= rd_hit ? smpf_pkg::RESP_OKAY : smpf_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end

   assign s_axi_arready = ~rvalid_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rdata   = rdata_r;
   assign s_axi_rresp   = rresp_r;
endmodule

// ### verification/smpf_board_model.sv
// Board model: pull-ups, AC and battery levels, fan tach source
module smpf_board_model (
   input  wire logic        aclk,
   input  wire logic [31:0] pad_out,
   input  wire logic [31:0] pad_oe,
   input  wire logic        ac_on,
   input  wire logic        bat_ok,
   input  wire logic        tach_on,
   output logic [31:0]      pad_in,
   output int               tach_cnt
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [31:0] ext;
   logic [3:0]  div_r = 4'h0;
   logic        tach_r = 1'h0;
   initial tach_cnt = 0;
   // Tach line toggles every 7 cycles while the fan spins
   always @(posedge aclk) begin
      if (tach_on) begin
         div_r <= (div_r == 4'h6) ? 4'h0 : div_r + 4'h1;
         if (div_r == 4'h6) begin
            tach_r <= ~tach_r;
            if (!tach_r) tach_cnt <= tach_cnt + 1;
         end
      end
   end
   // Undriven pins other than 0, 2 and 10 float high; keepalive is wired-low with a pull-up
   always_comb begin
      ext = 32'hFFFFFFFF;
      ext[0] = ac_on;
      ext[2] = bat_ok;
      ext[10] = tach_r;
      pad_in = (pad_oe & pad_out) | (~pad_oe & ext);
      pad_in[5] = ~(pad_oe[5] & ~pad_out[5]);
   end
endmodule

// ### verification/smpf_top_sva.sv
// Assertion checker for the system-management pin block
module smpf_top_chk (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_bvalid,
   input wire logic        sleep_s3_s5,
   input wire logic        mechanical_off_state,
   input wire logic        external_mgmt_irq_n,
   input wire logic [31:0] pad_in,
   input wire logic [31:0] pad_out,
   input wire logic [31:0] pad_oe,
   input wire logic        fan_drive_out0,
   input wire logic        memctl_halt_n,
   input wire logic        resume_block,
   input wire logic        resume_event
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic [10:0] slow_cnt_r;
   logic        slow_armed_r;
   logic [1:0]  slow_hold_r;
   // Cycles since the slow clock output last changed; restarts in step with the divider
   always_ff @(posedge aclk) begin
      slow_hold_r <= {slow_hold_r[0], !aresetn || mechanical_off_state};
      if (!aresetn || mechanical_off_state || slow_hold_r != 2'h0) begin
         slow_cnt_r   <= 11'h000;
         slow_armed_r <= 1'h0;
      end else if ($changed(pad_out[3])) begin
         slow_cnt_r   <= 11'h000;
         slow_armed_r <= 1'h1;
      end else begin
         slow_cnt_r   <= slow_cnt_r + 11'h001;
      end
   end
   AST_RST_OUT: assert property (disable iff (1'h0) !aresetn |=>
      pad_out[7] && pad_out[1] && !pad_out[9] && !fan_drive_out0 && memctl_halt_n)
      else $error("halt or fan outputs wrong after reset");
   AST_CTRL_SRC: assert property ($changed(memctl_halt_n) || $changed(pad_out[7]) |->
      $past(s_axi_bvalid) && !$past(s_axi_bvalid, 2))
      else $error("halt output changed without a register write");
   AST_GFX_SLEEP: assert property (sleep_s3_s5 |=> !pad_out[1])
      else $error("graphics halt not asserted in deep sleep");
   AST_KEEP_OFF: assert property (sleep_s3_s5 || mechanical_off_state |=> !(pad_oe[5] && !pad_out[5]))
      else $error("keepalive driven in deep sleep");
   AST_SLOW_OFF: assert property (mechanical_off_state |=> !pad_out[3])
      else $error("slow clock running in mechanical off");
   AST_SLOW_MAX: assert property (!mechanical_off_state |-> slow_cnt_r < 11'h264)
      else $error("slow clock half period too long");
   AST_SLOW_MIN: assert property ($changed(pad_out[3]) && slow_armed_r && !mechanical_off_state |->
      slow_cnt_r >= 11'h260)
      else $error("slow clock half period too short");
   AST_RESUME_BLK: assert property (resume_block |-> $past(!pad_in[2] && !pad_in[0], 2))
      else $error("resume blocked without weak battery and no AC");
   AST_EVT_PULSE: assert property (resume_event |=> !resume_event)
      else $error("resume event longer than one cycle");
   AST_EVT_SRC: assert property (resume_event |-> !$past(external_mgmt_irq_n, 3))
      else $error("resume event without interrupt input low");
endmodule

bind smpf_top smpf_top_chk smpf_top_chk_i (
   .aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid), .sleep_s3_s5(sleep_s3_s5),
   .mechanical_off_state(mechanical_off_state), .external_mgmt_irq_n(external_mgmt_irq_n),
   .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .fan_drive_out0(fan_drive_out0),
   .memctl_halt_n(memctl_halt_n), .resume_block(resume_block), .resume_event(resume_event));

// ### verification/system_mgmt_pin_functions_test.sv
// Self-checking bench for the system-management pin block
module system_mgmt_pin_functions_test;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [1:0] OKR = smpf_pkg::RESP_OKAY;
   localparam logic [1:0] ERR = smpf_pkg::RESP_SLVERR;
   logic        aclk = 1'h0, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0;
   logic        rready = 1'h0, irq_n = 1'h1, ac_on = 1'h1, bat_ok = 1'h1, tach_on = 1'h0;
   logic [3:0]  st = 4'h0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, pad_in, pad_out, pad_oe, rdata;
   logic        awready, wready, bvalid, arready, rvalid, fan0, mem_n, res_blk, res_evt;
   logic [1:0]  bresp, rresp;
   int          error_cnt = 0, num_checks = 0, tach_cnt;

   always #12.5 aclk = ~aclk;

   smpf_top smpf_top_i (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .c3_active(st[3]),
      .sleep_s1(st[2]), .sleep_s3_s5(st[1]), .mechanical_off_state(st[0]), .external_mgmt_irq_n(irq_n),
      .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .fan_drive_out0(fan0), .memctl_halt_n(mem_n),
      .resume_block(res_blk), .resume_event(res_evt));

   smpf_board_model smpf_board_model_i (.aclk(aclk), .pad_out(pad_out), .pad_oe(pad_oe), .ac_on(ac_on),
      .bat_ok(bat_ok), .tach_on(tach_on), .pad_in(pad_in), .tach_cnt(tach_cnt));

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         $display("mismatch %s expected %h seen %h", nm, e, g);
         error_cnt++;
      end
   endtask

   task automatic close_out;
      if (error_cnt == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic hang;
      $display("mismatch wait expected done seen timeout");
      error_cnt++;
      close_out();
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic ta, tw, tb;
      logic [1:0] r;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      for (int n = 0; n < 40; n++) begin
         @(negedge aclk);
         ta = awvalid & awready;
         tw = wvalid & wready;
         tb = bvalid;
         r = bresp;
         @(posedge aclk);
         if (ta) awvalid <= 1'h0;
         if (tw) wvalid <= 1'h0;
         if (tb) begin
            bready <= 1'h0;
            chk("bresp", 32'(er), 32'(r));
            return;
         end
      end
      hang();
   endtask

   task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e, m, input logic [1:0] er);
      logic ta, tb;
      logic [31:0] d;
      logic [1:0] r;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      for (int n = 0; n < 40; n++) begin
         @(negedge aclk);
         ta = arvalid & arready;
         tb = rvalid;
         d = rdata;
         r = rresp;
         @(posedge aclk);
         if (ta) arvalid <= 1'h0;
         if (tb) begin
            rready <= 1'h0;
            chk("rresp", 32'(er), 32'(r));
            chk(nm, e & m, d & m);
            return;
         end
      end
      hang();
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge aclk);
      @(negedge aclk);
   endtask

   task automatic t_regs;
      logic [7:0] ofs[6] = '{smpf_pkg::OFS_CTRL, smpf_pkg::OFS_FAN_CFG, smpf_pkg::OFS_TACH,
                             smpf_pkg::OFS_FUNC_SEL, smpf_pkg::OFS_GPIO_OE, smpf_pkg::OFS_GPIO_OUT};
      logic [31:0] rv[6] = '{32'(smpf_pkg::CTRL_RESET), 32'(smpf_pkg::FAN_CFG_RESET), 32'(smpf_pkg::TACH_RESET),
                             smpf_pkg::FUNC_SEL_RESET, smpf_pkg::GPIO_OE_RESET, smpf_pkg::GPIO_OUT_RESET};
      settle(2);
      chk("halt_after_rst", 32'h82, pad_out & 32'h82);
      for (int i = 0; i < 6; i++) rdc("reset_val", ofs[i], rv[i], 32'hFFFFFFFF, OKR);
      wr(smpf_pkg::OFS_FUNC_SEL, 32'hFFFFFFFF, OKR);
      rdc("func_sel", smpf_pkg::OFS_FUNC_SEL, smpf_pkg::FUNC_MASK, 32'hFFFFFFFF, OKR);
      wr(smpf_pkg::OFS_FUNC_SEL, 32'h0, OKR);
      wr(8'h40, 32'h1, ERR);
      rdc("unmapped", 8'h40, 32'h0, 32'hFFFFFFFF, ERR);
   endtask

   task automatic t_ctrl;
      logic [31:0] v[5] = '{32'h04, 32'h08, 32'h10, 32'h20, 32'h00};
      for (int i = 0; i < 5; i++) begin
         wr(smpf_pkg::OFS_CTRL, v[i], OKR);
         settle(2);
         chk("halt_pins", {28'h0, ~v[i][2], v[i][3], ~v[i][4], ~v[i][5]},
             {28'h0, pad_out[1], pad_oe[6] & ~pad_out[6], pad_out[7], mem_n});
      end
   endtask

   task automatic t_states;
      logic [7:0] cv[7] = '{8'h03, 8'h03, 8'h00, 8'h00, 8'h40, 8'h40, 8'h40};
      logic [3:0] sv[7] = '{4'h8, 4'h4, 4'hC, 4'h2, 4'h0, 4'h2, 4'h1};
      logic [2:0] ex[7] = '{3'h2, 3'h0, 3'h4, 3'h0, 3'h5, 3'h0, 3'h4};
      int k;
      logic p;
      for (int i = 0; i < 7; i++) begin
         wr(smpf_pkg::OFS_CTRL, 32'(cv[i]), OKR);
         st <= sv[i];
         settle(2);
         chk("state_pins", 32'(ex[i]),
             32'({pad_out[1], pad_oe[6] & ~pad_out[6], pad_oe[5] & ~pad_out[5]}));
      end
      for (int j = 0; j < 2; j++) begin
         @(posedge aclk);
         st <= (j == 0) ? 4'h1 : 4'h0;
         settle(1);
         p = pad_out[3];
         k = 0;
         repeat (2600) begin
            @(negedge aclk);
            if (pad_out[3] !== p) k++;
            p = pad_out[3];
         end
         chk("slow_edges", (j == 0) ? 32'h0 : 32'h1, (j == 0) ? 32'(k + p) : 32'(k == 4 || k == 5));
      end
   endtask

   task automatic t_events;
      int k;
      wr(smpf_pkg::OFS_STATUS, 32'h3, OKR);
      ac_on <= 1'h0;
      settle(5);
      rdc("status_ac", smpf_pkg::OFS_STATUS, 32'h9, 32'hF, OKR);
      bat_ok <= 1'h0;
      settle(4);
      chk("resume_block", 32'h1, 32'(res_blk));
      @(posedge aclk);
      ac_on <= 1'h1;
      settle(4);
      chk("resume_block", 32'h0, 32'(res_blk));
      @(posedge aclk);
      bat_ok <= 1'h1;
      wr(smpf_pkg::OFS_STATUS, 32'h3, OKR);
      irq_n <= 1'h0;
      k = 0;
      for (int n = 0; n < 8; n++) begin
         @(negedge aclk);
         k = k + res_evt;
         if (n == 7) chk("resume_event", 32'h1, 32'(k));
      end
      rdc("status_irq", smpf_pkg::OFS_STATUS, 32'h2, 32'h3, OKR);
      irq_n <= 1'h1;
      wr(smpf_pkg::OFS_STATUS, 32'h2, OKR);
      rdc("status_clr", smpf_pkg::OFS_STATUS, 32'h0, 32'h3, OKR);
   endtask

   task automatic t_fan;
      logic [7:0] du[3] = '{8'h00, 8'h40, 8'hC0};
      int base, k;
      wr(smpf_pkg::OFS_TACH, 32'h0, OKR);
      base = tach_cnt;
      tach_on <= 1'h1;
      settle(300);
      tach_on <= 1'h0;
      settle(4);
      rdc("tach", smpf_pkg::OFS_TACH, 32'(tach_cnt - base), 32'hFFFF, OKR);
      for (int i = 0; i < 3; i++) begin
         wr(smpf_pkg::OFS_FAN_CFG, {16'h0, du[i], 8'h00}, OKR);
         settle(256);
         k = 0;
         repeat (512) begin
            @(negedge aclk);
            k = k + fan0 + pad_out[9];
         end
         chk("fan_high", 32'({du[i], 2'h0}), 32'(k));
      end
   endtask

   task automatic t_gpio;
      logic [31:0] v[2] = '{32'h11, 32'h00};
      wr(smpf_pkg::OFS_FUNC_SEL, 32'h1, OKR);
      wr(smpf_pkg::OFS_GPIO_OE, 32'h11, OKR);
      for (int i = 0; i < 2; i++) begin
         wr(smpf_pkg::OFS_GPIO_OUT, v[i], OKR);
         settle(2);
         chk("gpio_pins", v[i] | 32'h1100, {16'h0, 3'h0, pad_oe[4], 3'h0, pad_oe[0], 3'h0, pad_out[4], 3'h0, pad_out[0]});
         rdc("gpio_in", smpf_pkg::OFS_GPIO_IN, v[i], 32'h11, OKR);
      end
   endtask

   initial begin
      repeat (9) @(posedge aclk);
      @(negedge aclk);
      chk("rst_oe", 32'h282, pad_oe);
      chk("rst_out", 32'h82, pad_out & 32'h282);
      chk("rst_misc", 32'h1, 32'({fan0, mem_n}));
      @(posedge aclk);
      aresetn <= 1'h1;
      t_regs();
      t_ctrl();
      t_states();
      t_events();
      t_fan();
      t_gpio();
      close_out();
   end

   initial begin
      repeat (60000) @(posedge aclk);
      hang();
   end
endmodule
